// File: add_with_carry_alu.sv
// Add-with-carry execution datapath with source fetch sequencer
module add_with_carry_alu (
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic start,
	input wire logic [7:0] opcode,
	input wire logic [7:0] operand,
	input wire alu_pkg::psw_view_t psw_in,
	input wire logic [7:0] acc_in,
	input wire logic [7:0] mem_rd_data,
	output logic mem_rd,
	output logic [7:0] mem_addr,
	output logic [7:0] acc_out,
	output alu_pkg::flags_t flags_out,
	output logic result_we,
	output logic busy,
	output logic refused
);
	import alu_pkg::*;

	// Opcode recognisers, shared by accept and form selection
	function automatic logic is_bank_op(input logic [7:0] op);
		return op[7:3] == BANK_REG_OPC_HI;
	endfunction : is_bank_op

	function automatic logic is_indirect_op(input logic [7:0] op);
		return op[7:1] == INDIRECT_OPC_HI;
	endfunction : is_indirect_op

	function automatic logic is_add_with_carry_op(input logic [7:0] op);
		return is_bank_op(op) || is_indirect_op(op) || op == DIRECT_OPC || op == IMMEDIATE_OPC;
	endfunction : is_add_with_carry_op

	// Registered sequencer, capture and output state
	alu_state_t state_r;
	alu_state_t state_nxt;
	src_form_t form_r;
	logic [7:0] opcode_r;
	logic [7:0] operand_r;
	logic [7:0] src_r;
	logic [7:0] src_nxt;
	logic mem_rd_r;
	logic mem_rd_nxt;
	logic [7:0] mem_addr_r;
	logic [7:0] mem_addr_nxt;
	logic [7:0] acc_r;
	flags_t flags_r;
	logic result_we_r;
	logic busy_r;
	logic refused_r;

	// Decode and datapath wires
	logic accept;
	src_form_t form_dec;
	logic [7:0] bank_reg_addr;
	logic [7:0] ptr_reg_addr;
	logic [7:0] sum;
	logic cy3;
	logic cy6;
	logic cy7;
	flags_t flags_calc;

	// Accept only in idle and only a recognised opcode
	// A start while busy is dropped, never queued
	assign accept = start && state_r == ST_IDLE && is_add_with_carry_op(opcode);

	// Addressing form decode
	assign form_dec = is_bank_op(opcode) ? SRC_BANK : // see RULE_06
		is_indirect_op(opcode) ? SRC_INDIRECT : // see RULE_08
		(opcode == DIRECT_OPC) ? SRC_DIRECT : // see RULE_07
		SRC_IMMEDIATE; // see RULE_09

	// Bank addresses use the bank selected now, not at accept time
	// A bank switch between accept and read is honoured
	assign bank_reg_addr = {3'h0, psw_in.bank_sel, opcode_r[REG_FIELD_MSB:REG_FIELD_LSB]}; // see RULE_10
	assign ptr_reg_addr = {3'h0, psw_in.bank_sel, 2'h0, opcode_r[PTR_BIT_POS]}; // see RULE_10

	// Adder on accumulator, source byte and current carry
	// Accumulator and carry matter in the execute cycle only
	carry_adder8 u_adder (
		.a(acc_in),
		.b(src_r),
		.cin(psw_in.carry),
		.sum(sum),
		.cy3(cy3),
		.cy6(cy6),
		.cy7(cy7)
	);

	// Flags from internal carries
	// Overflow compares the carry into bit 7 with the carry out
	assign flags_calc.carry = cy7; // see RULE_02
	assign flags_calc.half_carry_flag = cy3; // see RULE_03
	assign flags_calc.signed_overflow_flag = cy6 ^ cy7; // see RULE_04

	// Next state, read strobe, address and source capture
	// The read port answers one cycle after the strobe, so each
	// wait state holds until the strobe has dropped
	always_comb begin
		state_nxt = state_r;
		mem_rd_nxt = 1'b0;
		mem_addr_nxt = mem_addr_r;
		src_nxt = src_r;
		unique case (state_r)
			ST_IDLE: begin
				if (accept) begin
					unique case (form_dec) // see RULE_05
						SRC_IMMEDIATE: begin
							src_nxt = operand;
							state_nxt = ST_EXEC;
						end
						SRC_INDIRECT: begin
							state_nxt = ST_PTR_REQ;
						end
						SRC_DIRECT: begin
							state_nxt = ST_SRC_REQ;
						end
						SRC_BANK: begin
							state_nxt = ST_SRC_REQ;
						end
					endcase
				end
			end
			ST_PTR_REQ: begin
				mem_rd_nxt = 1'b1;
				mem_addr_nxt = ptr_reg_addr;
				state_nxt = ST_PTR_WAIT;
			end
			ST_PTR_WAIT: begin
				// Pointer byte stands one cycle after its strobe
				if (!mem_rd_r) begin
					mem_addr_nxt = mem_rd_data; // see RULE_08
					mem_rd_nxt = 1'b1;
					state_nxt = ST_SRC_WAIT;
				end
			end
			ST_SRC_REQ: begin
				mem_rd_nxt = 1'b1;
				mem_addr_nxt = (form_r == SRC_DIRECT) ? operand_r : bank_reg_addr; // see RULE_07
				state_nxt = ST_SRC_WAIT;
			end
			ST_SRC_WAIT: begin
				// Source byte stands one cycle after its strobe
				if (!mem_rd_r) begin
					src_nxt = mem_rd_data;
					state_nxt = ST_EXEC;
				end
			end
			ST_EXEC: begin
				state_nxt = ST_IDLE;
			end
			default: begin
				state_nxt = ST_IDLE;
			end
		endcase
	end

	// Sequencer registers
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_r <= ST_IDLE;
			mem_rd_r <= 1'b0;
			mem_addr_r <= ADDR_RST;
			src_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			mem_rd_r <= mem_rd_nxt;
			mem_addr_r <= mem_addr_nxt;
			src_r <= src_nxt;
		end
	end

	// Instruction capture at accept
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			opcode_r <= 8'h00;
			operand_r <= 8'h00;
			form_r <= SRC_BANK;
		end else if (accept) begin
			opcode_r <= opcode;
			operand_r <= operand;
			form_r <= form_dec;
		end
	end

	// Result and flag write-back
	// Outputs hold between pulses of result_we
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			acc_r <= ACC_RST;
			flags_r <= '0;
			result_we_r <= 1'b0;
		end else begin
			result_we_r <= state_r == ST_EXEC;
			if (state_r == ST_EXEC) begin
				acc_r <= sum; // see RULE_01
				flags_r <= flags_calc;
			end
		end
	end

	// Status outputs
	// Busy follows the next state so it drops with result_we
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			busy_r <= 1'b0;
			refused_r <= 1'b0;
		end else begin
			busy_r <= state_nxt != ST_IDLE;
			refused_r <= start && !accept;
		end
	end

	// Outputs straight from their flip-flops
	assign mem_rd = mem_rd_r;
	assign mem_addr = mem_addr_r;
	assign acc_out = acc_r;
	assign flags_out = flags_r;
	assign result_we = result_we_r;
	assign busy = busy_r;
	assign refused = refused_r;
endmodule : add_with_carry_alu

// File: add_with_carry_alu_test.sv
// Self-checking bench for the add-with-carry datapath
module add_with_carry_alu_test;
	timeunit 1ns;
	timeprecision 1ps;
	import alu_pkg::*;
	// Stimulus, outputs and bench state
	logic sys_clk = 1'b0, reset = 1'b1, start = 1'b0;
	logic [7:0] opcode = 8'h0, operand = 8'h0, acc_in = 8'h0, mem_rd_data = 8'h0;
	psw_view_t psw_in = '0;
	logic mem_rd, result_we, busy, refused;
	logic [7:0] mem_addr, acc_out, ram [256];
	flags_t flags_out;
	int fail_count = 0, checks_done = 0, cyc = 0;
	add_with_carry_alu dut (
		.sys_clk(sys_clk),
		.reset(reset),
		.start(start),
		.opcode(opcode),
		.operand(operand),
		.psw_in(psw_in),
		.acc_in(acc_in),
		.mem_rd_data(mem_rd_data),
		.mem_rd(mem_rd),
		.mem_addr(mem_addr),
		.acc_out(acc_out),
		.flags_out(flags_out),
		.result_we(result_we),
		.busy(busy),
		.refused(refused)
	);
	// Clock, memory answering one cycle late, hang guard
	always #12.5 sys_clk = ~sys_clk;
	always @(posedge sys_clk) mem_rd_data <= (mem_rd === 1'b1) ? ram[mem_addr] : ~mem_rd_data;
	always @(posedge sys_clk) if (++cyc == 2000) begin
		fail_count++;
		tally_and_finish();
	end
	task chk(input string n, input logic [7:0] e, g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task tally_and_finish;
		$display("mismatches %0d checks %0d", fail_count, checks_done);
		if (fail_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	// Issue one instruction, then judge result and flags
	task exec(input logic [7:0] op, d, a, v, input logic c, input logic [1:0] b);
		logic [8:0] s;
		logic [2:0] f;
		int k;
		int lat;
		s = a + v + c;
		f = {s[8], s[4] ^ a[4] ^ v[4], s[7] ^ a[7] ^ v[7] ^ s[8]};
		lat = (op == IMMEDIATE_OPC) ? 1 : (op[7:1] == INDIRECT_OPC_HI) ? 6 : 4;
		@(posedge sys_clk);
		opcode <= op;
		operand <= d;
		acc_in <= a;
		psw_in <= {c, b};
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		@(negedge sys_clk);
		chk("busy", 8'h1, 8'(busy));
		for (k = 0; k < 9 && result_we !== 1'b1; k++) @(negedge sys_clk);
		chk("latency", 8'(lat), 8'(k));
		chk("result_we", 8'h1, 8'(result_we));
		chk("busy", 8'h0, 8'(busy));
		chk("acc", s[7:0], acc_out);
		chk("flags", 8'(f), 8'(flags_out));
	endtask : exec
	// Every register of every bank
	task t_banks;
		for (int i = 0; i < 32; i++) begin
			ram[i] = 8'(i * 29 + 7);
			exec(8'h38 + 8'(i % 8), 8'h0, 8'(i * 53), ram[i], 1'(i), 2'(i / 8));
		end
	endtask : t_banks
	// Both pointer registers in two banks
	task t_ptr;
		for (int i = 0; i < 4; i++) begin
			ram[16 + i / 2 * 8 + i % 2] = 8'h40 + 8'(i);
			ram[64 + i] = 8'(i * 61 + 9);
			exec(8'h36 + 8'(i % 2), 8'h0, 8'h88, ram[64 + i], 1'(i), 2'(2 + i / 2));
		end
	endtask : t_ptr
	// Two-byte forms with known answers
	task t_two_byte;
		exec(8'h34, 8'haa, 8'hc3, 8'haa, 1'b1, 2'h0);
		chk("example", 8'h6e, acc_out);
		exec(8'h34, 8'hff, 8'hff, 8'hff, 1'b1, 2'h1);
		ram[8'h7e] = 8'h01;
		exec(8'h35, 8'h7e, 8'h7f, 8'h01, 1'b0, 2'h3);
	endtask : t_two_byte
	// Foreign opcode turned away
	task t_refuse;
		@(posedge sys_clk);
		opcode <= 8'h24;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		@(negedge sys_clk);
		chk("refused", 8'h1, 8'(refused));
		chk("busy", 8'h0, 8'(busy));
		@(posedge sys_clk);
		opcode <= IMMEDIATE_OPC;
		operand <= 8'h11;
		acc_in <= 8'h20;
		psw_in <= '0;
		start <= 1'b1;
		@(posedge sys_clk);
		@(posedge sys_clk);
		start <= 1'b0;
		@(negedge sys_clk);
		chk("busy refused", 8'h1, 8'(refused));
		chk("acc", 8'h31, acc_out);
		@(negedge sys_clk);
		chk("refused", 8'h0, 8'(refused));
		chk("result_we", 8'h0, 8'(result_we));
	endtask : t_refuse
	// Reset, then each scenario
	initial begin
		repeat (3) @(posedge sys_clk);
		reset <= 1'b0;
		t_banks();
		t_ptr();
		t_two_byte();
		t_refuse();
		tally_and_finish();
	end
endmodule : add_with_carry_alu_test

// File: alu_pkg.sv
// Constants, types and behaviour list for the add-with-carry datapath
// Behaviour
// RULE_01 - Accumulator takes low eight bits of accumulator plus source plus carry.
// RULE_02 - Carry flag set on carry out of bit 7, else cleared.
// RULE_03 - Half-carry flag set on carry out of bit 3, else cleared.
// RULE_04 - Overflow flag set when carries out of bits 6 and 7 differ.
// RULE_05 - Source is bank register, direct address, pointer indirect or immediate.
// RULE_06 - Bank register form is one byte 00111rrr, low bits pick register.
// RULE_07 - Direct form is 00110101 followed by source address byte.
// RULE_08 - Indirect form is 0011011i, bit 0 picks pointer register.
// RULE_09 - Immediate form is 00110100 followed by the constant byte.
// RULE_10 - Register and pointer numbers resolve against bank selected at execution.
package alu_pkg;
	// Opcode patterns
	localparam logic [4:0] BANK_REG_OPC_HI = 5'h07;
	localparam logic [7:0] DIRECT_OPC = 8'h35;
	localparam logic [6:0] INDIRECT_OPC_HI = 7'h1b;
	localparam logic [7:0] IMMEDIATE_OPC = 8'h34;
	// Field positions inside the opcode
	localparam int REG_FIELD_LSB = 0;
	localparam int REG_FIELD_MSB = 2;
	localparam int PTR_BIT_POS = 0;
	// Reset values
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [7:0] ADDR_RST = 8'h00;

	// Program status bits seen by the datapath
	typedef struct packed {
		logic carry;
		logic [1:0] bank_sel;
	} psw_view_t;

	// Flags produced by the addition
	typedef struct packed {
		logic carry;
		logic half_carry_flag;
		logic signed_overflow_flag;
	} flags_t;

	// Addressing form of an accepted opcode
	typedef enum logic [1:0] {
		SRC_BANK = 2'h0,
		SRC_DIRECT = 2'h1,
		SRC_INDIRECT = 2'h2,
		SRC_IMMEDIATE = 2'h3
	} src_form_t;

	// Sequencer states, Gray coded along the register and direct path
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_SRC_REQ = 3'h1,
		ST_SRC_WAIT = 3'h3,
		ST_EXEC = 3'h2,
		ST_PTR_REQ = 3'h6,
		ST_PTR_WAIT = 3'h7
	} alu_state_t;
endpackage : alu_pkg

// File: alu_props.sv
// Checker for the add-with-carry datapath
module alu_props import alu_pkg::*; (
	input logic sys_clk, reset, start, mem_rd, result_we, busy, refused,
	input logic [7:0] opcode, operand, acc_in, mem_rd_data, mem_addr, acc_out,
	input alu_pkg::psw_view_t psw_in,
	input alu_pkg::flags_t flags_out
);
	// Operands as seen at the execute step
	logic [7:0] ea, s, op;
	logic [1:0] bk;
	logic ec, rq;
	wire lg = opcode[7:3] == BANK_REG_OPC_HI || opcode[7:2] == 6'h0d;
	wire tk = start && !busy && lg;
	wire [8:0] sm = ea + s + ec;
	wire [8:0] cx = sm ^ {1'b0, ea ^ s};
	// Source is the operand, or the last byte read
	always_ff @(posedge sys_clk) begin
		ea <= acc_in;
		ec <= psw_in.carry;
		bk <= psw_in.bank_sel;
		rq <= mem_rd;
		op <= tk ? opcode : op;
		s <= tk ? operand : rq ? mem_rd_data : s;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_acc_sum: assert property (result_we |-> acc_out == sm[7:0])
		else $error("acc");
	a_carry_out: assert property (result_we |-> flags_out.carry == sm[8])
		else $error("carry");
	a_half_carry: assert property (result_we |-> flags_out.half_carry_flag == cx[4])
		else $error("half carry");
	a_signed_ovf: assert property (
		result_we |-> flags_out.signed_overflow_flag == (cx[7] ^ sm[8]))
		else $error("overflow");
	a_bank_read: assert property (
		tk && opcode[7:3] == BANK_REG_OPC_HI |-> ##2 mem_rd && mem_addr == {3'h0, bk, op[2:0]}
		##3 result_we) else $error("bank read");
	a_direct_read: assert property (
		tk && opcode == DIRECT_OPC |-> ##2 mem_rd && mem_addr == s ##3 result_we)
		else $error("direct read");
	a_ptr_read: assert property (
		tk && opcode[7:1] == INDIRECT_OPC_HI |-> ##2 mem_rd && mem_addr == {3'h0, bk, 2'h0, op[0]}
		##2 mem_rd && mem_addr == s ##3 result_we) else $error("pointer read");
	a_refuse_bad: assert property (start && (busy || !lg) |=> refused)
		else $error("no refusal");
endmodule : alu_props
bind add_with_carry_alu alu_props u_props (.*);

// File: carry_adder8.sv
// Eight-bit adder with carry-in exposing carries out of bits 3, 6 and 7
module carry_adder8 (
	input wire logic [7:0] a,
	input wire logic [7:0] b,
	input wire logic cin,
	output logic [7:0] sum,
	output logic cy3,
	output logic cy6,
	output logic cy7
);
	logic [4:0] low_sum;
	logic [3:0] mid_sum;
	logic [1:0] top_sum;

	// Split adder so internal carries are visible
	assign low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin}; // see RULE_01
	assign mid_sum = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, low_sum[4]};
	assign top_sum = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, mid_sum[3]};
	assign sum = {top_sum[0], mid_sum[2:0], low_sum[3:0]};
	assign cy3 = low_sum[4];
	assign cy6 = mid_sum[3];
	assign cy7 = top_sum[1];
endmodule : carry_adder8
